//--- verilog/tmc_regs.vh
// Functional notes
// - Type field bits 31:28 reads fixed 2, address/data match trigger.
// - Debug-only-write clear: Debug Mode and machine mode may both write.
// - Debug-only-write set: only Debug Mode writes; machine-mode writes dropped.
// - Debug-only-write bit changes only from Debug Mode writes.
// - Range-limit field bits 26:21 reads fixed 31.
// - Hit flag set by hardware whenever the trigger matches.
// - Software may write hit flag to either value when its write is allowed; a same-cycle match keeps it set.
// - Compare-source 0 compares address, 1 compares store data.
// - Action before triggering instruction commits; timing bit reads 0.
// - Execute-address hit on side-effect load suppresses its bus transaction.
// - Size-low reads 0; accesses of any size can match.
// - Action 0 on fire raises a breakpoint exception.
// - Action 1 on fire enters Debug Mode; only when debug-only-write set.
// - Configuration word is CSR 0x7a1 via standard CSR accesses.
// - Chain bit set: match only when next trigger also matches.
// - Only triggers 0 and 2 may set the chain bit.
// - Reserved bits read 0; writable fields are write-any read-legal.
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_CSR_SELECT 12'h7a0
`define TMC_CSR_CONFIG 12'h7a1
`define TMC_CSR_COMPARE 12'h7a2
`define TMC_TYPE_VAL 4'h2
`define TMC_MASKMAX_VAL 6'h1f
`define TMC_BIT_DMODE 27
`define TMC_BIT_HIT 20
`define TMC_BIT_SELECT 19
`define TMC_ACT_LO 12
`define TMC_ACT_HI 15
`define TMC_BIT_CHAIN 11
`define TMC_MATCH_LO 7
`define TMC_MATCH_HI 10
`define TMC_BIT_M 6
`define TMC_BIT_EXEC 2
`define TMC_BIT_STORE 1
`define TMC_BIT_LOAD 0
`define TMC_ACT_BREAK 4'h0
`define TMC_ACT_DEBUG 4'h1
`endif

//--- verilog/tmc_compare.v
`timescale 1ns/1ns
// One comparator: exact or NAPOT match against the compare value
module tmc_compare #(
    parameter WIDTH = 32
) (
    // Operands
    input wire [WIDTH-1:0] value,
    input wire [WIDTH-1:0] compare,
    input wire napot,
    // Result
    output wire hit
);
    reg [WIDTH-1:0] care;
    reg seen_zero;
    integer i;

    // NAPOT: bits up to and including the lowest zero of compare are ignored
    always @* begin
        care = {WIDTH{1'b1}};
        seen_zero = 1'b0;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (napot && !seen_zero) begin
                care[i] = 1'b0;
                if (!compare[i]) begin
                    seen_zero = 1'b1;
                end
            end
        end
    end

    assign hit = ((value ^ compare) & care) == {WIDTH{1'b0}};
endmodule

//--- verilog/tmc_trigger.v
`timescale 1ns/1ns
`include "tmc_regs.vh"
module tmc_trigger #(
    parameter NUM = 4,
    parameter XLEN = 32
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // CSR access from the pipeline
    input wire csr_wr,
    input wire [11:0] csr_addr,
    input wire [31:0] csr_wdata,
    input wire debug_mode,
    output reg [31:0] csr_rdata,
    // Candidate instruction at commit point
    input wire cand_valid,
    input wire cand_machine_mode,
    input wire cand_exec,
    input wire cand_load,
    input wire cand_store,
    input wire cand_side_effect,
    input wire [XLEN-1:0] cand_pc,
    input wire [XLEN-1:0] cand_addr,
    input wire [XLEN-1:0] cand_store_data,
    // Actions toward the pipeline
    output reg take_breakpoint,
    output reg take_debug_entry,
    output reg block_bus_access,
    output reg [NUM-1:0] fired
);
    reg [1:0] sel;
    reg [NUM-1:0] dmode;
    reg [NUM-1:0] hitf;
    reg [NUM-1:0] selbit;
    reg [NUM-1:0] chain;
    reg [NUM-1:0] napot;
    reg [NUM-1:0] men;
    reg [NUM-1:0] en_x;
    reg [NUM-1:0] en_s;
    reg [NUM-1:0] en_l;
    reg [NUM-1:0] act;
    reg [XLEN-1:0] cmp [0:NUM-1];
    wire [NUM-1:0] raw;
    wire [NUM-1:0] xhit;
    reg [NUM-1:0] eff;
    reg next_brk;
    reg next_dbg;
    reg next_blk;
    integer k;
    integer r;
    // Write strobes; dmode guards the config word and the compare value alike
    wire cfg_we;
    wire cmp_we;

    // Write permission: dmode protects the selected trigger from M-mode
    function wr_ok;
        input dm;
        input dbg;
        begin
            wr_ok = dbg | ~dm;
        end
    endfunction

    // Decoded once so both write paths see the same protection
    assign cfg_we = csr_wr && csr_addr == `TMC_CSR_CONFIG
        && wr_ok(dmode[sel], debug_mode);
    assign cmp_we = csr_wr && csr_addr == `TMC_CSR_COMPARE
        && wr_ok(dmode[sel], debug_mode);

    // Per-trigger comparator and qualification
    genvar g;
    generate
        for (g = 0; g < NUM; g = g + 1) begin : g_trig
            wire [XLEN-1:0] val;
            wire eq_v;
            wire eq_x;
            assign val = selbit[g] ? cand_store_data : cand_addr;
            tmc_compare #(.WIDTH(XLEN)) u_cmp (
                .value(val),
                .compare(cmp[g]),
                .napot(napot[g]),
                .hit(eq_v)
            );
            tmc_compare #(.WIDTH(XLEN)) u_cmpx (
                .value(cand_pc),
                .compare(cmp[g]),
                .napot(napot[g]),
                .hit(eq_x)
            );
            // Data-select only meaningful for stores
            assign raw[g] = cand_valid & cand_machine_mode & men[g] & (
                (en_x[g] & cand_exec & ~selbit[g] & eq_x) |
                (en_l[g] & cand_load & ~selbit[g] & eq_v) |
                (en_s[g] & cand_store & eq_v));
            assign xhit[g] = cand_valid & cand_machine_mode & men[g] & en_x[g]
                & cand_exec & eq_x;
        end
    endgenerate

    // Chain resolution: even triggers gate on their odd partner
    always @* begin
        eff = {NUM{1'b0}};
        next_brk = 1'b0;
        next_dbg = 1'b0;
        next_blk = 1'b0;
        // Pairs 0/1 and 2/3; a chained pair needs both halves in one cycle
        for (k = 0; k < NUM; k = k + 1) begin
            if (k % 2 == 1) begin
                eff[k] = raw[k] & (~chain[k-1] | raw[k-1]);
                if (chain[k-1]) begin
                    eff[k-1] = raw[k-1] & raw[k];
                end else begin
                    eff[k-1] = raw[k-1];
                end
            end
        end
        for (k = 0; k < NUM; k = k + 1) begin
            // Chained even trigger defers its action to the partner
            if (eff[k] && !((k % 2 == 0) && chain[k])) begin
                if (act[k] && dmode[k]) begin
                    next_dbg = 1'b1;
                end else begin
                    next_brk = 1'b1;
                end
                if (xhit[k] && cand_load && cand_side_effect) begin
                    next_blk = 1'b1;
                end
            end
        end
        // Debug entry outranks a breakpoint on the same instruction
        if (next_dbg) begin
            next_brk = 1'b0;
        end
    end

    // Actions registered at the commit point, before retirement
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            take_breakpoint <= 1'b0;
            take_debug_entry <= 1'b0;
            block_bus_access <= 1'b0;
            fired <= {NUM{1'b0}};
        end else begin
            take_breakpoint <= next_brk;
            take_debug_entry <= next_dbg;
            block_bus_access <= next_blk;
            fired <= eff;
        end
    end

    // CSR state, one copy per trigger
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel <= 2'h0;
            dmode <= {NUM{1'b0}};
            hitf <= {NUM{1'b0}};
            selbit <= {NUM{1'b0}};
            chain <= {NUM{1'b0}};
            napot <= {NUM{1'b0}};
            men <= {NUM{1'b0}};
            en_x <= {NUM{1'b0}};
            en_s <= {NUM{1'b0}};
            en_l <= {NUM{1'b0}};
            act <= {NUM{1'b0}};
            for (r = 0; r < NUM; r = r + 1) begin
                cmp[r] <= {XLEN{1'b0}};
            end
        end else begin
            // Hardware set; a same-cycle software write still loses to a match
            hitf <= hitf | eff;
            if (csr_wr && csr_addr == `TMC_CSR_SELECT) begin
                sel <= csr_wdata[1:0];
            end
            if (cfg_we) begin
                if (debug_mode) begin
                    dmode[sel] <= csr_wdata[`TMC_BIT_DMODE];
                end
                hitf[sel] <= csr_wdata[`TMC_BIT_HIT] | eff[sel];
                selbit[sel] <= csr_wdata[`TMC_BIT_SELECT];
                // Odd triggers cannot chain
                chain[sel] <= csr_wdata[`TMC_BIT_CHAIN] & ~sel[0];
                // WARL: unsupported match sizes fall back to exact
                napot[sel] <= (csr_wdata[`TMC_MATCH_HI:`TMC_MATCH_LO] == 4'h1);
                men[sel] <= csr_wdata[`TMC_BIT_M];
                en_x[sel] <= csr_wdata[`TMC_BIT_EXEC];
                en_s[sel] <= csr_wdata[`TMC_BIT_STORE];
                en_l[sel] <= csr_wdata[`TMC_BIT_LOAD];
                // WARL: reserved action codes read back as 0
                act[sel] <= (csr_wdata[`TMC_ACT_HI:`TMC_ACT_LO] == `TMC_ACT_DEBUG);
            end
            if (cmp_we) begin
                cmp[sel] <= csr_wdata[XLEN-1:0];
            end
        end
    end

    // Read mux; fixed fields and reserved bits are constants
    always @* begin
        csr_rdata = 32'h0;
        if (csr_addr == `TMC_CSR_SELECT) begin
            csr_rdata[1:0] = sel;
        end else if (csr_addr == `TMC_CSR_CONFIG) begin
            csr_rdata[31:28] = `TMC_TYPE_VAL;
            csr_rdata[`TMC_BIT_DMODE] = dmode[sel];
            csr_rdata[26:21] = `TMC_MASKMAX_VAL;
            csr_rdata[`TMC_BIT_HIT] = hitf[sel];
            csr_rdata[`TMC_BIT_SELECT] = selbit[sel];
            csr_rdata[18] = 1'b0;
            csr_rdata[17:16] = 2'h0;
            // Only the legal codes are stored, so upper action and match bits read 0
            csr_rdata[`TMC_ACT_LO] = act[sel];
            csr_rdata[`TMC_BIT_CHAIN] = chain[sel];
            csr_rdata[`TMC_MATCH_LO] = napot[sel];
            csr_rdata[`TMC_BIT_M] = men[sel];
            csr_rdata[`TMC_BIT_EXEC] = en_x[sel];
            csr_rdata[`TMC_BIT_STORE] = en_s[sel];
            csr_rdata[`TMC_BIT_LOAD] = en_l[sel];
        end else if (csr_addr == `TMC_CSR_COMPARE) begin
            csr_rdata = cmp[sel];
        end
    end
endmodule

//--- verification/tmc_trigger_checker.sv
`timescale 1ns/1ns
// Ties action outputs and config readback to their causes
module tmc_trigger_checker #(
    parameter NUM = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Watched ports
    input wire [11:0] csr_addr,
    input wire [31:0] csr_rdata,
    input wire cand_valid,
    input wire cand_load,
    input wire cand_side_effect,
    input wire take_breakpoint,
    input wire take_debug_entry,
    input wire block_bus_access,
    input wire [NUM-1:0] fired
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Config word is being read
    wire cfg_rd = csr_addr == 12'h7a1;
    a_type_code: assert property (cfg_rd |-> csr_rdata[31:28] == 4'h2)
        else $error("type field wrong");
    a_range_limit: assert property (cfg_rd |-> csr_rdata[26:21] == 6'h1f)
        else $error("range limit wrong");
    a_fixed_zero: assert property (cfg_rd |->
        csr_rdata[18:16] == 3'h0 && csr_rdata[5:3] == 3'h0)
        else $error("fixed zero bits set");
    a_debug_wins: assert property (take_debug_entry |-> !take_breakpoint)
        else $error("breakpoint beside debug entry");
    a_idle_quiet: assert property (!cand_valid |=> !(take_breakpoint || take_debug_entry))
        else $error("action without candidate");
    a_block_cause: assert property (block_bus_access |->
        $past(cand_valid && cand_load && cand_side_effect))
        else $error("bus block without side-effect load");
    a_fired_cause: assert property (|fired |-> $past(cand_valid))
        else $error("fired without candidate");
    a_action_fired: assert property ((take_breakpoint || take_debug_entry) |-> |fired)
        else $error("action without a fired trigger");
    c_break: cover property (take_breakpoint);
    c_debug: cover property (take_debug_entry);
    c_block: cover property (block_bus_access);
    c_chain: cover property (fired[0] && fired[1]);
endmodule
bind tmc_trigger tmc_trigger_checker #(.NUM(NUM)) tmc_trigger_checker_i (.core_clk(core_clk),
    .rst(rst), .csr_addr(csr_addr), .csr_rdata(csr_rdata), .cand_valid(cand_valid),
    .cand_load(cand_load), .cand_side_effect(cand_side_effect),
    .take_breakpoint(take_breakpoint), .take_debug_entry(take_debug_entry),
    .block_bus_access(block_bus_access), .fired(fired));

//--- verification/tmc_pipe_model.sv
`timescale 1ns/1ns
// Commit stage of the pipeline: one candidate per request
module tmc_pipe_model (
    // Clock and request
    input wire core_clk,
    input wire go,
    input wire [2:0] kind,
    input wire [31:0] opnd,
    // Candidate toward the trigger block
    output reg cand_valid,
    output reg cand_machine_mode,
    output reg cand_exec,
    output reg cand_load,
    output reg cand_store,
    output reg cand_side_effect,
    output reg [31:0] cand_pc,
    output reg [31:0] cand_addr,
    output reg [31:0] cand_store_data
);
    initial begin
        {cand_valid, cand_exec, cand_load, cand_store, cand_side_effect} = 5'h0;
        cand_machine_mode = 1'b1;
        {cand_pc, cand_addr, cand_store_data} = 96'h0;
    end
    // Idle operands toggle so a stale value never looks like a match
    // Updated by NBA on the edge: no race with the bench driving go
    always @(posedge core_clk) begin
        cand_valid <= go;
        {cand_store, cand_load, cand_exec} <= go ? kind : 3'h0;
        cand_side_effect <= go & kind[1];
        cand_pc <= go ? opnd : ~cand_pc;
        cand_addr <= go ? opnd : ~cand_addr;
        cand_store_data <= go ? opnd : ~cand_store_data;
    end
endmodule

//--- verification/tmc_trigger_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the trigger configuration block
module tmc_trigger_bench;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg csr_wr = 1'b0;
    reg [11:0] csr_addr = 12'h000;
    reg [31:0] csr_wdata = 32'h0;
    reg debug_mode = 1'b0;
    reg go = 1'b0;
    reg [2:0] kind = 3'h0;
    reg [31:0] opnd = 32'h0;
    reg [31:0] seed = 32'h3a7e;
    reg [31:0] w, v, a;
    reg [31:0] c = 32'h0;
    integer mismatches = 0;
    integer n_checks = 0;
    integer i;
    wire [31:0] csr_rdata, cand_pc, cand_addr, cand_store_data;
    wire cand_valid, cand_machine_mode, cand_exec, cand_load, cand_store, cand_side_effect;
    wire take_breakpoint, take_debug_entry, block_bus_access;
    wire [3:0] fired;
    always #20 core_clk = ~core_clk;
    tmc_trigger tmc_trigger_i (.core_clk(core_clk), .rst(rst), .csr_wr(csr_wr),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .debug_mode(debug_mode),
        .csr_rdata(csr_rdata), .cand_valid(cand_valid), .cand_machine_mode(cand_machine_mode),
        .cand_exec(cand_exec), .cand_load(cand_load), .cand_store(cand_store),
        .cand_side_effect(cand_side_effect), .cand_pc(cand_pc), .cand_addr(cand_addr),
        .cand_store_data(cand_store_data), .take_breakpoint(take_breakpoint),
        .take_debug_entry(take_debug_entry), .block_bus_access(block_bus_access), .fired(fired));
    tmc_pipe_model tmc_pipe_model_i (.core_clk(core_clk), .go(go), .kind(kind), .opnd(opnd),
        .cand_valid(cand_valid), .cand_machine_mode(cand_machine_mode), .cand_exec(cand_exec),
        .cand_load(cand_load), .cand_store(cand_store), .cand_side_effect(cand_side_effect),
        .cand_pc(cand_pc), .cand_addr(cand_addr), .cand_store_data(cand_store_data));
    // Galois step of a 32-bit LFSR
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    // Legal readback of a write to trigger 3, which cannot chain
    function [31:0] exp_cfg(input [31:0] d, input dm);
        exp_cfg = 32'h23e00000 | (d & 32'h00180047) | {4'h0, dm, 27'h0}
            | {19'h0, d[15:12] == 4'h1, 4'h0, d[10:7] == 4'h1, 7'h0};
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [11:0] ad, input [31:0] d, input dm);
        begin
            @(posedge core_clk) #1;
            csr_wr = 1'b1;
            csr_addr = ad;
            csr_wdata = d;
            debug_mode = dm;
            @(posedge core_clk) #1;
            csr_wr = 1'b0;
            csr_wdata = ~d;
        end
    endtask
    task rd(input [11:0] ad, input [31:0] exp);
        begin
            csr_addr = ad;
            #2 check(csr_rdata, exp);
        end
    endtask
    // Candidate offered for one cycle, actions read one cycle later
    task offer(input [2:0] k, input [31:0] op, input [2:0] exp, input [3:0] expf);
        begin
            @(posedge core_clk) #1;
            go = 1'b1;
            kind = k;
            opnd = op;
            @(posedge core_clk) #1;
            go = 1'b0;
            @(posedge core_clk) #1;
            check({take_breakpoint, take_debug_entry, block_bus_access}, exp);
            check(fired, expf);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        rd(12'h7a1, 32'h23e00000);
        wr(12'h7a1, 32'hffffffff, 1'b0);
        rd(12'h7a1, 32'h23f80847);
        wr(12'h7a0, 32'h1, 1'b0);
        wr(12'h7a1, 32'hffffffff, 1'b0);
        rd(12'h7a1, 32'h23f80047);
        wr(12'h7a0, 32'h3, 1'b0);
        for (i = 0; i < 24; i = i + 1) begin
            seed = lfsr(seed);
            w = seed & 32'hffff1fff;
            wr(12'h7a1, w, 1'b1);
            rd(12'h7a1, exp_cfg(w, w[27]));
            seed = lfsr(seed);
            v = seed & 32'hffff1fff;
            wr(12'h7a1, v, 1'b0);
            rd(12'h7a1, w[27] ? exp_cfg(w, 1'b1) : exp_cfg(v, 1'b0));
            wr(12'h7a2, v, 1'b0);
            if (!w[27]) begin
                c = v;
            end
            rd(12'h7a2, c);
        end
        a = lfsr(seed);
        wr(12'h7a2, a, 1'b1);
        wr(12'h7a1, 32'h00000044, 1'b1);
        offer(3'h1, a, 3'h4, 4'h8);
        rd(12'h7a1, 32'h23f00044);
        offer(3'h1, a ^ 32'h1, 3'h0, 4'h0);
        offer(3'h3, a, 3'h5, 4'h8);
        wr(12'h7a1, 32'h08001044, 1'b1);
        offer(3'h1, a, 3'h2, 4'h8);
        // Debug action without dmode falls back to a breakpoint
        wr(12'h7a1, 32'h00001044, 1'b1);
        offer(3'h1, a, 3'h4, 4'h8);
        wr(12'h7a1, 32'h00080042, 1'b1);
        offer(3'h4, a, 3'h4, 4'h8);
        // Range match: low four bits ignored, bit 4 still compared
        wr(12'h7a2, {a[31:4], 4'h7}, 1'b1);
        wr(12'h7a1, 32'h000000c4, 1'b1);
        offer(3'h1, {a[31:4], 4'h8}, 3'h4, 4'h8);
        offer(3'h1, a ^ 32'h10, 3'h0, 4'h0);
        wr(12'h7a1, 32'h0, 1'b1);
        wr(12'h7a0, 32'h0, 1'b0);
        rd(12'h7a1, 32'h23f80847);
        // Chained pair 0/1: load on trigger 0, execute on trigger 1
        wr(12'h7a2, a, 1'b0);
        wr(12'h7a1, 32'h00000841, 1'b0);
        wr(12'h7a0, 32'h1, 1'b0);
        wr(12'h7a2, a, 1'b0);
        wr(12'h7a1, 32'h00000044, 1'b0);
        offer(3'h1, a, 3'h0, 4'h0);
        offer(3'h3, a, 3'h5, 4'h3);
        // Second reset in mid-run
        @(posedge core_clk) #1 rst = 1'b1;
        @(posedge core_clk) #1 rst = 1'b0;
        rd(12'h7a2, 32'h0);
        rd(12'h7a1, 32'h23e00000);
        complete_run;
    end
    // Watchdog, several times the expected run
    initial begin
        #(40 * 2000);
        mismatches = mismatches + 1;
        complete_run;
    end
endmodule
